// ===== src/afl_pkg.sv
// Functional notes
// - standard mode, no reads: flag low at D-m
// - async full flag set on write edge
// - async full flag cleared on read edge
// - sync full flag updates on write edges only
// - standard mode empty flag low when count<=n
// - fall-through mode empty flag low when count<=n+1
// - async empty flag set on read edge
// - async empty flag cleared on write edge
// - sync empty flag updates on read edges only
// - read data on low 36/18/9 bits
// - serial enable low shifts one offset bit
package afl_pkg;
  // avalon byte addresses
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_COUNT = 4'h4;
  localparam logic [3:0] ADDR_OFFSET = 4'h8;
  // status fields
  localparam int ST_AFULL = 0;
  localparam int ST_AEMPTY = 1;
  localparam int ST_AFULL_ASYNC = 2;
  localparam int ST_AEMPTY_ASYNC = 3;
  localparam int ST_FALL_THRU = 4;
  // offset register fields, full offset low half
  localparam int OFS_W = 16;
  localparam int OFS_EMPTY_LSB = 16;
  localparam int EXT_W = 18;
  // output width select codes
  localparam logic [1:0] WSEL_36 = 2'h0;
  localparam logic [1:0] WSEL_18 = 2'h1;
  localparam logic [1:0] WSEL_9 = 2'h2;
  localparam int DATA_W = 36;
  localparam logic [35:0] MASK_36 = 36'hfffffffff;
  localparam logic [35:0] MASK_18 = 36'h00003ffff;
  localparam logic [35:0] MASK_9 = 36'h0000001ff;
  // reset values
  localparam logic [15:0] FULL_OFS_RST = 16'h007f;
  localparam logic [15:0] EMPTY_OFS_RST = 16'h007f;
endpackage

// ===== src/afl_flags.sv
`timescale 1ns/100ps
module afl_flags #(
  parameter int DEPTH = 4096,
  parameter int CNT_W = $clog2(DEPTH + 1)
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // buffer side pins
  input wire logic master_reset_n,
  input wire logic wr_clk_in,
  input wire logic wr_en_n_in,
  input wire logic rd_clk_in,
  input wire logic rd_en_n_in,
  input wire logic [35:0] rd_word_in,
  // static configuration
  input wire logic first_word_fall_through_mode,
  input wire logic afull_async_cfg,
  input wire logic aempty_async_cfg,
  input wire logic [1:0] out_width_sel,
  // serial offset load
  input wire logic serial_clk_in,
  input wire logic serial_data_in,
  input wire logic serial_load_enable_n,
  // flags and data
  output logic almost_full_flag_n,
  output logic almost_empty_flag_n,
  output logic [35:0] read_data_out,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  localparam int EW = afl_pkg::EXT_W;
  localparam int NS = 7;

  logic rst_s1_ff, rst_s2_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  wire logic rst_sync_n = rst_s2_ff;

  // pin synchronisers; a level counts once stages 2 and 3 agree
  logic [NS-1:0] pin_in, s1_ff, s2_ff, s3_ff, lvl_ff, nxt_lvl;
  assign pin_in = {serial_load_enable_n, serial_data_in, serial_clk_in,
                   rd_en_n_in, rd_clk_in, wr_en_n_in, wr_clk_in};
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_sync
      always_comb begin
        nxt_lvl[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : lvl_ff[gi];
      end
      always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          s1_ff[gi] <= 1'b1;
          s2_ff[gi] <= 1'b1;
          s3_ff[gi] <= 1'b1;
          lvl_ff[gi] <= 1'b1;
        end else begin
          s1_ff[gi] <= pin_in[gi];
          s2_ff[gi] <= s1_ff[gi];
          s3_ff[gi] <= s2_ff[gi];
          lvl_ff[gi] <= nxt_lvl[gi];
        end
      end
    end
  endgenerate

  logic mres_s1_ff, mres_s2_ff, mres_s3_ff, mres_lvl_ff, nxt_mres_lvl;
  always_comb begin
    nxt_mres_lvl = (mres_s2_ff == mres_s3_ff) ? mres_s3_ff : mres_lvl_ff;
  end
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mres_s1_ff <= 1'b0;
      mres_s2_ff <= 1'b0;
      mres_s3_ff <= 1'b0;
      mres_lvl_ff <= 1'b0;
    end else begin
      mres_s1_ff <= master_reset_n;
      mres_s2_ff <= mres_s1_ff;
      mres_s3_ff <= mres_s2_ff;
      mres_lvl_ff <= nxt_mres_lvl;
    end
  end
  wire logic mres_act = ~mres_lvl_ff;

  wire logic wr_rise = nxt_lvl[0] & ~lvl_ff[0];
  wire logic rd_rise = nxt_lvl[2] & ~lvl_ff[2];
  wire logic sclk_rise = nxt_lvl[4] & ~lvl_ff[4];
  wire logic sdat = nxt_lvl[5];
  wire logic sload_en = ~nxt_lvl[6];

  // fill count and flags
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic afull_ff, nxt_afull, aempty_ff, nxt_aempty;
  logic afull_async_ff, nxt_afull_async, aempty_async_ff, nxt_aempty_async;
  logic fall_thru_ff, nxt_fall_thru;
  logic [31:0] ofs_ff, nxt_ofs;
  logic wr_ok, rd_ok;
  logic [EW-1:0] full_thr, empty_thr, cnt_x;
  logic at_full, at_empty;

  always_comb begin
    wr_ok = wr_rise & ~nxt_lvl[1] & (cnt_ff != CNT_W'(DEPTH));
    rd_ok = rd_rise & ~nxt_lvl[3] & (cnt_ff != '0);
    nxt_cnt = cnt_ff;
    if (wr_ok && !rd_ok) begin
      nxt_cnt = cnt_ff + CNT_W'(1);
    end else if (rd_ok && !wr_ok) begin
      nxt_cnt = cnt_ff - CNT_W'(1);
    end
    cnt_x = EW'(nxt_cnt);
    full_thr = EW'(DEPTH) - EW'(ofs_ff[afl_pkg::OFS_W-1:0]);
    if (EW'(ofs_ff[afl_pkg::OFS_W-1:0]) > EW'(DEPTH)) begin
      full_thr = '0;
    end
    empty_thr = EW'(ofs_ff[afl_pkg::OFS_EMPTY_LSB +: afl_pkg::OFS_W]);
    if (fall_thru_ff) begin
      empty_thr = empty_thr + EW'(1);
    end
    at_full = cnt_x >= full_thr;
    at_empty = cnt_x <= empty_thr;
    nxt_afull = afull_ff;
    nxt_aempty = aempty_ff;
    nxt_afull_async = afull_async_ff;
    nxt_aempty_async = aempty_async_ff;
    nxt_fall_thru = fall_thru_ff;
    if (mres_act) begin
      // timing choice caught at master reset
      nxt_afull_async = afull_async_cfg;
      nxt_aempty_async = aempty_async_cfg;
      nxt_fall_thru = first_word_fall_through_mode;
      nxt_cnt = '0;
      nxt_afull = 1'b1;
      nxt_aempty = 1'b0;
    end else begin
      if (afull_async_ff) begin
        if (wr_ok && at_full) begin
          nxt_afull = 1'b0;
        end else if (rd_ok && !at_full) begin
          nxt_afull = 1'b1;
        end
      end else if (wr_ok) begin
        nxt_afull = ~at_full;
      end
      if (aempty_async_ff) begin
        if (rd_ok && at_empty) begin
          nxt_aempty = 1'b0;
        end else if (wr_ok && !at_empty) begin
          nxt_aempty = 1'b1;
        end
      // low at n words or less, n+1 or less in fall-through mode
      end else if (rd_ok) begin
        nxt_aempty = ~at_empty;
      end
    end
  end

  // offsets: serial shift or bus write
  logic wr_acc, rd_acc;
  logic wait_ff, nxt_wait;
  logic [31:0] rdata_ff, nxt_rdata;
  always_comb begin
    wr_acc = avs_write & ~wait_ff;
    rd_acc = avs_read & ~wait_ff;
    nxt_ofs = ofs_ff;
    if (sload_en && sclk_rise) begin
      nxt_ofs = {ofs_ff[30:0], sdat};
    end else if (wr_acc && avs_address == afl_pkg::ADDR_OFFSET) begin
      nxt_ofs = avs_writedata;
    end
    // one wait cycle then answer
    nxt_wait = ~((avs_read | avs_write) & wait_ff);
    nxt_rdata = rdata_ff;
    if ((avs_read | avs_write) && wait_ff) begin
      nxt_rdata = 32'h0;
      case (avs_address)
        afl_pkg::ADDR_STATUS: begin
          nxt_rdata[afl_pkg::ST_AFULL] = afull_ff;
          nxt_rdata[afl_pkg::ST_AEMPTY] = aempty_ff;
          nxt_rdata[afl_pkg::ST_AFULL_ASYNC] = afull_async_ff;
          nxt_rdata[afl_pkg::ST_AEMPTY_ASYNC] = aempty_async_ff;
          nxt_rdata[afl_pkg::ST_FALL_THRU] = fall_thru_ff;
        end
        afl_pkg::ADDR_COUNT: begin
          nxt_rdata = 32'(cnt_ff);
        end
        afl_pkg::ADDR_OFFSET: begin
          nxt_rdata = ofs_ff;
        end
        default: begin
          nxt_rdata = 32'h0;
        end
      endcase
    end
  end

  // read data width select
  logic [35:0] q_ff, nxt_q;
  always_comb begin
    case (out_width_sel)
      afl_pkg::WSEL_18: nxt_q = rd_word_in & afl_pkg::MASK_18;
      afl_pkg::WSEL_9: nxt_q = rd_word_in & afl_pkg::MASK_9;
      default: nxt_q = rd_word_in & afl_pkg::MASK_36;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cnt_ff <= '0;
      afull_ff <= 1'b1;
      aempty_ff <= 1'b0;
      afull_async_ff <= 1'b0;
      aempty_async_ff <= 1'b0;
      fall_thru_ff <= 1'b0;
      ofs_ff <= {afl_pkg::EMPTY_OFS_RST, afl_pkg::FULL_OFS_RST};
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0;
      q_ff <= 36'h0;
    end else begin
      cnt_ff <= nxt_cnt;
      afull_ff <= nxt_afull;
      aempty_ff <= nxt_aempty;
      afull_async_ff <= nxt_afull_async;
      aempty_async_ff <= nxt_aempty_async;
      fall_thru_ff <= nxt_fall_thru;
      ofs_ff <= nxt_ofs;
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
      q_ff <= nxt_q;
    end
  end

  assign almost_full_flag_n = afull_ff;
  assign almost_empty_flag_n = aempty_ff;
  assign read_data_out = q_ff;
  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  sequence s_wr_reach;
    !mres_act && wr_ok && at_full;
  endsequence
  sequence s_rd_leave;
    !mres_act && rd_ok && !at_full;
  endsequence

  property p_afull_sync;
    !afull_async_ff ##0 s_wr_reach |=> !afull_ff;
  endproperty
  a_afull_sync: assert property (p_afull_sync)
    else $error("full flag not low at threshold");

  property p_afull_async_set;
    afull_async_ff ##0 s_wr_reach |=> !afull_ff;
  endproperty
  a_afull_async_set: assert property (p_afull_async_set)
    else $error("async full flag not set on write");

  property p_afull_async_clr;
    afull_async_ff ##0 s_rd_leave |=> afull_ff;
  endproperty
  a_afull_async_clr: assert property (p_afull_async_clr)
    else $error("async full flag not cleared on read");

  property p_afull_hold;
    !afull_async_ff && !wr_ok && !mres_act |=> $stable(afull_ff);
  endproperty
  a_afull_hold: assert property (p_afull_hold)
    else $error("sync full flag moved without write edge");

  property p_aempty_sync;
    !aempty_async_ff && !fall_thru_ff && !mres_act && rd_ok
      && cnt_x <= empty_thr |=> !aempty_ff;
  endproperty
  a_aempty_sync: assert property (p_aempty_sync)
    else $error("empty flag not low at offset");

  property p_aempty_fall_thru;
    fall_thru_ff && !mres_act && rd_ok && !aempty_async_ff
      && cnt_x == empty_thr |=> !aempty_ff;
  endproperty
  a_aempty_fall_thru: assert property (p_aempty_fall_thru)
    else $error("fall-through empty flag not low at n+1");

  property p_aempty_async_set;
    aempty_async_ff && !mres_act && rd_ok && at_empty |=> !aempty_ff;
  endproperty
  a_aempty_async_set: assert property (p_aempty_async_set)
    else $error("async empty flag not set on read");

  property p_aempty_async_clr;
    aempty_async_ff && !mres_act && wr_ok && !at_empty |=> aempty_ff;
  endproperty
  a_aempty_async_clr: assert property (p_aempty_async_clr)
    else $error("async empty flag not cleared on write");

  property p_aempty_hold;
    !aempty_async_ff && !rd_ok && !mres_act |=> $stable(aempty_ff);
  endproperty
  a_aempty_hold: assert property (p_aempty_hold)
    else $error("sync empty flag moved without read edge");

  property p_width9;
    out_width_sel == afl_pkg::WSEL_9 |=> read_data_out[35:9] == 27'h0;
  endproperty
  a_width9: assert property (p_width9)
    else $error("upper data bits not clear in 9-bit mode");

  property p_shift;
    sload_en && sclk_rise |=> ofs_ff[0] == $past(sdat);
  endproperty
  a_shift: assert property (p_shift)
    else $error("serial bit not shifted in");

  property p_cfg_hold;
    !mres_act && !$past(mres_act) |-> $stable(afull_async_ff);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("timing mode changed outside master reset");

  property p_mrs;
    mres_act |=> afull_ff && cnt_ff == '0;
  endproperty
  a_mrs: assert property (p_mrs)
    else $error("master reset did not clear count and flag");

  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  property p_bus;
    s_req |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus answer not after one wait cycle");
endmodule

// ===== dv/afl_host_model.sv
`timescale 1ns/100ps
module afl_host_model (
  // bench requests
  input wire logic clk,
  input wire logic go,
  input wire logic [1:0] kind,
  input wire logic sbit,
  input wire logic slow,
  output logic busy,
  // host pins
  output logic wr_clk_in,
  output logic wr_en_n_in,
  output logic rd_clk_in,
  output logic rd_en_n_in,
  output logic [35:0] rd_word_in,
  output logic serial_clk_in,
  output logic serial_data_in,
  output logic serial_load_enable_n
);
  int h;
  // storage word moves every cycle so stale data never looks valid
  always @(posedge clk) rd_word_in <= rd_word_in * 36'h5 + 36'h3b;
  initial begin
    {busy, wr_clk_in, rd_clk_in, serial_clk_in, serial_data_in} = 5'h0;
    {wr_en_n_in, rd_en_n_in, serial_load_enable_n} = 3'h7;
    rd_word_in = 36'h9a5c3e1f7;
    forever begin
      @(posedge clk);
      if (go) begin
        h = slow ? 6 : 3;
        busy <= 1'b1;
        // enable low, then one serial clock rise per bit
        wr_en_n_in <= kind != 2'h0;
        rd_en_n_in <= kind != 2'h1;
        serial_load_enable_n <= kind != 2'h2;
        serial_data_in <= sbit;
        repeat (h) @(posedge clk);
        wr_clk_in <= kind == 2'h0;
        rd_clk_in <= kind == 2'h1;
        serial_clk_in <= kind[1];
        repeat (h) @(posedge clk);
        {wr_clk_in, rd_clk_in, serial_clk_in} <= 3'h0;
        repeat (h) @(posedge clk);
        {wr_en_n_in, rd_en_n_in, serial_load_enable_n} <= 3'h7;
        // released data line must not keep the last bit
        serial_data_in <= ~sbit;
        busy <= 1'b0;
      end
    end
  end
endmodule

// ===== dv/fifo_almost_flag_logic_tb.sv
`timescale 1ns/100ps
module fifo_almost_flag_logic_tb;
  localparam int DEP = 16;
  int seed = 32'h918b;
  int miscompares, samples_checked, cyc, cnt, m, n;
  logic clk, rst_n, master_reset_n, fw, pa, pe, go, sbit, slow, busy, mon;
  logic ef, ee;
  logic [1:0] sel, kind, ps;
  logic [35:0] rd_word_in, read_data_out, pw;
  logic [31:0] q, v, avs_writedata, avs_readdata;
  logic [3:0] avs_address;
  logic wr_clk_in, wr_en_n_in, rd_clk_in, rd_en_n_in, serial_clk_in;
  logic serial_data_in, serial_load_enable_n, almost_full_flag_n;
  logic almost_empty_flag_n, avs_read, avs_write, avs_waitrequest;

  afl_flags #(.DEPTH(DEP)) dut (.clk, .rst_n, .master_reset_n, .wr_clk_in,
    .wr_en_n_in, .rd_clk_in, .rd_en_n_in, .rd_word_in,
    .first_word_fall_through_mode(fw), .afull_async_cfg(pa),
    .aempty_async_cfg(pe), .out_width_sel(sel), .serial_clk_in,
    .serial_data_in, .serial_load_enable_n, .almost_full_flag_n,
    .almost_empty_flag_n,
    .read_data_out, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest);
  afl_host_model host (.clk, .go, .kind, .sbit, .slow, .busy, .wr_clk_in,
    .wr_en_n_in, .rd_clk_in, .rd_en_n_in, .rd_word_in, .serial_clk_in,
    .serial_data_in, .serial_load_enable_n);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic full_lvl(int c);
    return c < DEP - m;
  endfunction
  function automatic logic empty_lvl(int c);
    return c > n + int'(fw);
  endfunction
  function automatic logic [35:0] msk(logic [1:0] s);
    if (s == 2'h1) return afl_pkg::MASK_18;
    if (s == 2'h2) return afl_pkg::MASK_9;
    return afl_pkg::MASK_36;
  endfunction

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [35:0] seen, logic [35:0] want);
    samples_checked++;
    if (seen !== want) begin
      $display("Error %s expected %h seen %h", nm, want, seen);
      miscompares++;
    end
  endtask

  // one edge first so a release and a new request never share a step
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d,
      output logic [31:0] r);
    int k;
    k = 0;
    @(posedge clk);
    {avs_address, avs_writedata, avs_read, avs_write} <= {a, d, ~w, w};
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && k < 20) begin
      @(posedge clk);
      k++;
    end
    r = avs_readdata;
    {avs_read, avs_write} <= 2'h0;
    if (k == 20) begin
      miscompares++;
      test_done;
    end
  endtask

  task automatic reg_chk(string nm, logic [3:0] a, logic [31:0] want);
    bus(1'b0, a, 32'h0, q);
    chk(nm, 36'(q), 36'(want));
  endtask

  task automatic op(logic [1:0] k, logic b);
    int t;
    t = 0;
    {kind, sbit, go} <= {k, b, 1'b1};
    slow <= 1'($random(seed));
    sel <= 2'($random(seed));
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (busy === 1'b1 && t < 100) begin
      @(posedge clk);
      t++;
    end
    if (t == 100) begin
      miscompares++;
      test_done;
    end
  endtask

  // sync flags move only on their own clock, async on both
  task automatic ev(logic [1:0] k);
    op(k, 1'b0);
    if (k == 2'h0 && cnt < DEP) cnt++;
    if (k == 2'h1 && cnt > 0) cnt--;
    if (k == 2'h0 || pa) ef = full_lvl(cnt);
    if (k == 2'h1 || pe) ee = empty_lvl(cnt);
    chk("full flag", 36'(almost_full_flag_n), 36'(ef));
    chk("empty flag", 36'(almost_empty_flag_n), 36'(ee));
  endtask

  task automatic mreset(logic [2:0] c);
    {fw, pe, pa, master_reset_n} <= {c, 1'b0};
    repeat (8) @(posedge clk);
    master_reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    cnt = 0;
    ef = 1'b1;
    ee = 1'b0;
  endtask

  always @(negedge clk) begin
    if (mon) chk("read data", read_data_out, pw & msk(ps));
    pw = rd_word_in;
    ps = sel;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 12000) begin
      miscompares++;
      test_done;
    end
  end

  initial begin
    {rst_n, master_reset_n, fw, pa, pe, sel, go, kind, sbit, slow} = '0;
    {avs_address, avs_writedata, avs_read, avs_write} = '0;
    mon = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    mon = 1'b1;
    for (int md = 0; md < 4; md++) begin
      mreset({md[0] ^ md[1], md[1], md[0]});
      reg_chk("status", afl_pkg::ADDR_STATUS, {27'h0, fw, pe, pa, 2'b01});
      m = 1 + $unsigned($random(seed)) % 6;
      n = $unsigned($random(seed)) % 5;
      bus(1'b1, afl_pkg::ADDR_OFFSET, {16'(n), 16'(m)}, q);
      for (int i = 0; i <= DEP; i++) ev(2'h0);
      reg_chk("count", afl_pkg::ADDR_COUNT, DEP);
      for (int i = 0; i <= DEP; i++) ev(2'h1);
      repeat (24) ev(2'(($random(seed) & 3) == 0));
      reg_chk("count", afl_pkg::ADDR_COUNT, 32'(cnt));
    end
    bus(1'b1, 4'hc, 32'hffffffff, q);
    reg_chk("unmapped", 4'hc, 32'h0);
    reg_chk("offset", afl_pkg::ADDR_OFFSET, {16'(n), 16'(m)});
    v = $random(seed);
    for (int i = 31; i >= 0; i--) op(2'h2, v[i]);
    repeat (3) op(2'h3, 1'b1);
    reg_chk("serial offset", afl_pkg::ADDR_OFFSET, v);
    test_done;
  end
endmodule
